// ---- host_bus_pkg.sv ----
// Purpose: constants for the host-side controller of a quad UART bus port
// Assumes: one clock, mclk at 125 MHz, which also serves as the device host clock
// Notes: the device map is outside this block; only its address shape is kept here
//
// Notes on behaviour
// - Host clock over twice any device clock
// - Access only while chip select held low
// - Direction high writes, low reads
// - Chip select idle during interrupt acknowledge
// - Host starts acknowledge with ack line low
// - Master reset low at least ten clocks
// - Async: one access per select assertion
// - Burst: access every four clocks
// - Select held four, or 4n in burst
// - Eight-bit bus, device drives on reads
`default_nettype none

package host_bus_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int ADDR_UNUSED_BIT = 6;
	localparam int ADDR_HALF_BIT = 7;
	localparam int CLK_PERIOD_NS = 8;
	localparam int PHASES_PER_ACCESS = 4;
	localparam int RESET_MIN_CLOCKS = 10;
	localparam int RESET_CNT_W = 4;
	localparam int PHASE_CNT_W = 3;
	localparam int ACK_HOLD_CLOCKS = 4;
	localparam logic [RESET_CNT_W-1:0] RESET_CNT_LAST = RESET_CNT_W'(RESET_MIN_CLOCKS - 1);
	localparam logic [PHASE_CNT_W-1:0] PHASE_LAST = PHASE_CNT_W'(PHASES_PER_ACCESS - 1);
	localparam logic [PHASE_CNT_W-1:0] ACK_LAST = PHASE_CNT_W'(ACK_HOLD_CLOCKS - 1);
	localparam logic [PHASE_CNT_W-1:0] PHASE_ZERO = 3'h0;
	localparam logic [RESET_CNT_W-1:0] RESET_CNT_ZERO = 4'h0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;

	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_IDLE = 3'h1,
		ST_ACCESS = 3'h2,
		ST_GAP = 3'h3,
		ST_IACK = 3'h4
	} bus_state_t;
endpackage

`default_nettype wire

// ---- pin_sync.sv ----
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to mclk
// Notes: output changes only when stages two and three agree
`default_nettype none

module pin_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic pin,
	output logic level
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= RESET_LEVEL;
			s2 <= RESET_LEVEL;
			s3 <= RESET_LEVEL;
		end else if (clk_en) begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			level <= RESET_LEVEL;
		end else if (clk_en && (s2 == s3)) begin
			level <= s3;
		end
	end
endmodule

`default_nettype wire

// ---- host_bus_master.sv ----
// Purpose: host-side master driving the quad UART parallel bus port
// Assumes: mclk is forwarded to the device as its host clock
// Notes: one request at a time; burst mode holds chip select across accesses
`default_nettype none

module host_bus_master
	import host_bus_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic restart,
	input wire logic burst_mode,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [host_bus_pkg::ADDR_W-1:0] req_addr,
	input wire logic [host_bus_pkg::DATA_W-1:0] req_wdata,
	input wire logic req_last,
	output logic req_ready,
	output logic rsp_valid,
	output logic [host_bus_pkg::DATA_W-1:0] rsp_rdata,
	input wire logic iack_req,
	output logic iack_done,
	output logic irq_pending,
	output logic busy,
	output logic master_reset_n,
	output logic chip_select_n,
	output logic write_not_read,
	output logic [host_bus_pkg::ADDR_W-1:0] addr,
	input wire logic [host_bus_pkg::DATA_W-1:0] data_in,
	output logic [host_bus_pkg::DATA_W-1:0] data_out,
	output logic data_oe_n,
	input wire logic transfer_done_n,
	input wire logic interrupt_request_n,
	output logic int_ack_cycle_n
);
	import host_bus_pkg::*;

	bus_state_t state;
	logic [PHASE_CNT_W-1:0] phase;
	logic [RESET_CNT_W-1:0] reset_cnt;
	logic done_level;
	logic done_prev;
	logic done_fall;
	logic irq_level;
	logic in_burst;
	logic take_req;
	logic phase_end;

	// ==========================================================
	// Pin synchronisers
	pin_sync #(.RESET_LEVEL(1'b1)) u_sync_done (
		.mclk(mclk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.pin(transfer_done_n),
		.level(done_level)
	);

	pin_sync #(.RESET_LEVEL(1'b1)) u_sync_irq (
		.mclk(mclk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.pin(interrupt_request_n),
		.level(irq_level)
	);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			done_prev <= 1'b1;
		end else if (clk_en) begin
			done_prev <= done_level;
		end
	end

	// Device acknowledge seen, open-drain low means finished
	assign done_fall = done_prev && !done_level;

	// Interrupt pending follows the filtered request line
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_pending <= 1'b0;
		end else if (clk_en) begin
			irq_pending <= !irq_level;
		end
	end

	// ==========================================================
	// Master reset pulse, held at least ten clocks
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reset_cnt <= RESET_CNT_ZERO;
			master_reset_n <= 1'b0;
		end else if (clk_en) begin
			if (restart) begin
				reset_cnt <= RESET_CNT_ZERO;
				master_reset_n <= 1'b0;
			end else if (!master_reset_n) begin
				if (reset_cnt == RESET_CNT_LAST) begin
					master_reset_n <= 1'b1;
				end else begin
					reset_cnt <= reset_cnt + 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Bus sequencer
	assign take_req = req_valid && req_ready;
	assign phase_end = (phase == PHASE_LAST);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_RESET;
			phase <= PHASE_ZERO;
			in_burst <= 1'b0;
		end else if (clk_en) begin
			if (restart || !master_reset_n) begin
				state <= ST_RESET;
				phase <= PHASE_ZERO;
				in_burst <= 1'b0;
			end else begin
				case (state)
					ST_RESET: begin
						state <= ST_IDLE;
					end
					ST_IDLE: begin
						phase <= PHASE_ZERO;
						if (iack_req) begin
							state <= ST_IACK;
						end else if (take_req) begin
							state <= ST_ACCESS;
							in_burst <= burst_mode && !req_last;
						end
					end
					ST_ACCESS: begin
						// Four phases per access; select kept for whole span
						phase <= phase + 1'b1;
						if (phase_end) begin
							phase <= PHASE_ZERO;
							if (in_burst && req_valid) begin
								in_burst <= !req_last;
							end else begin
								state <= ST_GAP;
								in_burst <= 1'b0;
							end
						end
					end
					ST_GAP: begin
						state <= ST_IDLE;
					end
					ST_IACK: begin
						if (done_fall || phase == ACK_LAST) begin
							state <= ST_GAP;
						end
						phase <= phase + 1'b1;
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// Ready for a new request at idle, or at burst continuation
	always_comb begin
		req_ready = 1'b0;
		if (state == ST_IDLE && !iack_req && master_reset_n) begin
			req_ready = 1'b1;
		end else if (state == ST_ACCESS && phase_end && in_burst) begin
			req_ready = 1'b1;
		end
	end

	// ==========================================================
	// Pin drivers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			chip_select_n <= 1'b1;
			write_not_read <= 1'b0;
			addr <= ADDR_ZERO;
			data_out <= DATA_ZERO;
			data_oe_n <= 1'b1;
		end else if (clk_en) begin
			if (take_req) begin
				chip_select_n <= 1'b0;
				write_not_read <= req_write;
				addr <= req_addr;
				addr[ADDR_UNUSED_BIT] <= 1'b0;
				data_out <= req_wdata;
				data_oe_n <= !req_write;
			end else if (state == ST_ACCESS && phase_end) begin
				chip_select_n <= 1'b1;
				data_oe_n <= 1'b1;
			end else if (state != ST_ACCESS) begin
				chip_select_n <= 1'b1;
				data_oe_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			int_ack_cycle_n <= 1'b1;
		end else if (clk_en) begin
			int_ack_cycle_n <= !(state == ST_IDLE && iack_req && master_reset_n) &&
				!(state == ST_IACK && !(done_fall || phase == ACK_LAST));
		end
	end

	// ==========================================================
	// Answers: read data captured at last phase
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= DATA_ZERO;
			iack_done <= 1'b0;
			busy <= 1'b0;
		end else if (clk_en) begin
			rsp_valid <= (state == ST_ACCESS) && phase_end;
			if (state == ST_ACCESS && phase_end && !write_not_read) begin
				rsp_rdata <= data_in;
			end
			iack_done <= (state == ST_IACK) && (done_fall || phase == ACK_LAST);
			busy <= (state != ST_IDLE) || take_req;
		end
	end
endmodule

`default_nettype wire

// ---- bus_chk_checker.sv ----
// Purpose: pin timing checks for the host bus master
// Assumes: mclk is also the device host clock
// Notes: bound from the bench top file
`default_nettype none
module bus_chk
	import host_bus_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic rsp_valid,
	input wire logic irq_pending,
	input wire logic master_reset_n,
	input wire logic chip_select_n,
	input wire logic write_not_read,
	input wire logic [host_bus_pkg::ADDR_W-1:0] addr,
	input wire logic data_oe_n,
	input wire logic interrupt_request_n,
	input wire logic int_ack_cycle_n
);
	import host_bus_pkg::*;

	int low_cnt;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// ====
	// Reset width counter
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			low_cnt <= 0;
		else if (!master_reset_n)
			low_cnt <= low_cnt + 1;
		else
			low_cnt <= 0;
	end
	sequence s_sel4;
		!chip_select_n[*4];
	endsequence
	sequence s_hold3;
		($stable(addr) && $stable(write_not_read))[*3];
	endsequence
	property p_len; $fell(chip_select_n) |-> s_sel4; endproperty
	property p_rsp; $fell(chip_select_n) |-> ##[3:5] rsp_valid; endproperty
	property p_gap; $rose(chip_select_n) |=> chip_select_n; endproperty
	property p_hold; $fell(chip_select_n) |-> ##1 s_hold3; endproperty
	property p_a6; !chip_select_n |-> !addr[ADDR_UNUSED_BIT]; endproperty
	property p_oe; !data_oe_n |-> !chip_select_n && write_not_read; endproperty
	property p_iack; !int_ack_cycle_n |-> chip_select_n; endproperty
	property p_rst; $rose(master_reset_n) |-> low_cnt >= RESET_MIN_CLOCKS; endproperty
	// A frozen clock enable holds the synchroniser, so only enabled cycles count
	property p_irq; (clk_en && !interrupt_request_n)[*8] |-> irq_pending; endproperty
	a_len: assert property (p_len) else $error("select too short");
	a_rsp: assert property (p_rsp) else $error("no response");
	a_gap: assert property (p_gap) else $error("no select gap");
	a_hold: assert property (p_hold) else $error("address moved");
	a_a6: assert property (p_a6) else $error("address bit six set");
	a_oe: assert property (p_oe) else $error("bus driven off write");
	a_iack: assert property (p_iack) else $error("select in ack cycle");
	a_rst: assert property (p_rst) else $error("reset too short");
	a_irq: assert property (p_irq) else $error("interrupt missed");
endmodule
`default_nettype wire

// ---- uart_dev_model.sv ----
// Purpose: device side of the host bus port
// Assumes: open-drain pulls are resolved by the bench
// Notes: undriven data toggles every clock
`default_nettype none
module uart_dev_model (
	input wire logic host_clock,
	input wire logic master_reset_n,
	input wire logic chip_select_n,
	input wire logic write_not_read,
	input wire logic [7:0] addr,
	input wire logic [7:0] data_out,
	input wire logic int_ack_cycle_n,
	input wire logic irq_src,
	output logic [7:0] data_in,
	output logic done_pull,
	output logic irq_pull
);
	logic [7:0] mem [0:127];
	logic [7:0] last = 8'h00;
	logic [1:0] ph;
	logic [1:0] ack_cnt;
	wire logic [6:0] idx = {addr[7], addr[5:0]};
	// ====
	// Pins
	assign data_in = (!chip_select_n && !write_not_read) ? mem[idx] : ~last;
	assign done_pull = (!chip_select_n && ph == 2'h3) || (!int_ack_cycle_n && ack_cnt == 2'h2);
	assign irq_pull = irq_src && master_reset_n;
	always_ff @(posedge host_clock) begin
		last <= data_in;
	end
	always_ff @(posedge host_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			ph <= 2'h0;
			ack_cnt <= 2'h0;
		end else begin
			ph <= chip_select_n ? 2'h0 : ph + 2'h1;
			ack_cnt <= int_ack_cycle_n ? 2'h0 : ack_cnt + 2'h1;
		end
	end
	always_ff @(posedge host_clock) begin
		if (!chip_select_n && write_not_read && ph == 2'h3)
			mem[idx] <= data_out;
	end
endmodule
`default_nettype wire

// ---- test_host_bus_master.sv ----
// Purpose: self-checking bench for host_bus_master
// Assumes: device model on the far side
// Notes: rows cover single accesses, hand tests the rest
`default_nettype none
module test_host_bus_master;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic w; logic [7:0] a; logic [7:0] d;} row_t;
	logic mclk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, restart = 1'b0, burst_mode = 1'b0;
	logic req_valid = 1'b0, req_write = 1'b0, req_last = 1'b0, iack_req = 1'b0, irq_src = 1'b0;
	logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, rsp_rdata, addr, data_in, data_out;
	logic req_ready, rsp_valid, iack_done, irq_pending, busy, master_reset_n, chip_select_n;
	logic write_not_read, data_oe_n, int_ack_cycle_n, done_pull, irq_pull;
	wire logic transfer_done_n = ~done_pull;
	wire logic interrupt_request_n = ~irq_pull;
	int err_count = 0, n_compared = 0, i, k;
	row_t rows [6] = '{'{1'b1, 8'h00, 8'hA5}, '{1'b1, 8'hC1, 8'h3C}, '{1'b1, 8'h80, 8'h7E},
		'{1'b0, 8'h00, 8'hA5}, '{1'b0, 8'h81, 8'h3C}, '{1'b0, 8'h80, 8'h7E}};
	host_bus_master u_dut (.mclk, .arst_n, .clk_en, .restart, .burst_mode, .req_valid,
		.req_write, .req_addr, .req_wdata, .req_last, .req_ready, .rsp_valid, .rsp_rdata,
		.iack_req, .iack_done, .irq_pending, .busy, .master_reset_n, .chip_select_n,
		.write_not_read, .addr, .data_in, .data_out, .data_oe_n, .transfer_done_n,
		.interrupt_request_n, .int_ack_cycle_n);
	uart_dev_model u_dev (.host_clock(mclk), .master_reset_n, .chip_select_n, .write_not_read,
		.addr, .data_out, .int_ack_cycle_n, .irq_src, .data_in, .done_pull, .irq_pull);
	always #(host_bus_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e)
			$display("mismatch %s expected %h seen %h", n, e, g);
		if (g !== e)
			err_count++;
	endtask
	task automatic req(logic w, logic [7:0] a, logic [7:0] d, logic l);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		req_last <= l;
		// Ready is looked at mid-cycle, then the request is taken at the next rising edge
		@(negedge mclk);
		for (k = 0; k < 60 && req_ready !== 1'b1; k++)
			@(negedge mclk);
		chk("req_ready", 8'h01, req_ready);
		@(posedge mclk);
	endtask
	task automatic wait_rsp();
		req_valid <= 1'b0;
		@(negedge mclk);
		for (k = 0; k < 20 && rsp_valid !== 1'b1; k++)
			@(negedge mclk);
		chk("rsp_valid", 8'h01, rsp_valid);
		@(posedge mclk);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ====
	// Main sequence
	initial begin
		@(negedge mclk);
		chk("cs_rst", 8'h01, chip_select_n);
		chk("oe_rst", 8'h01, data_oe_n);
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		chk("mreset", 8'h00, master_reset_n);
		for (i = 0; i < 6; i++) begin
			req(rows[i].w, rows[i].a, rows[i].d, 1'b1);
			wait_rsp();
			if (!rows[i].w)
				chk("rdata", rows[i].d, rsp_rdata);
		end
		burst_mode <= 1'b1;
		req(1'b1, 8'h10, 8'h5A, 1'b0);
		req(1'b1, 8'h11, 8'hC3, 1'b1);
		req_valid <= 1'b0;
		for (k = 0; k < 30 && busy !== 1'b0; k++)
			@(negedge mclk);
		chk("busy", 8'h00, busy);
		@(posedge mclk);
		burst_mode <= 1'b0;
		for (i = 0; i < 2; i++) begin
			req(1'b0, 8'h10 + 8'(i), 8'h00, 1'b1);
			wait_rsp();
			chk("burst", i ? 8'hC3 : 8'h5A, rsp_rdata);
		end
		clk_en <= 1'b0;
		irq_src <= 1'b1;
		repeat (10) @(posedge mclk);
		chk("frozen", 8'h00, irq_pending);
		clk_en <= 1'b1;
		repeat (10) @(posedge mclk);
		chk("irq", 8'h01, irq_pending);
		irq_src <= 1'b0;
		repeat (10) @(posedge mclk);
		chk("irq_clr", 8'h00, irq_pending);
		iack_req <= 1'b1;
		for (k = 0; k < 20 && iack_done !== 1'b1; k++)
			@(negedge mclk);
		chk("iack", 8'h01, iack_done);
		@(posedge mclk);
		iack_req <= 1'b0;
		restart <= 1'b1;
		@(posedge mclk);
		restart <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("restart", 8'h00, master_reset_n);
		req(1'b0, 8'h00, 8'h00, 1'b1);
		wait_rsp();
		chk("after_restart", 8'hA5, rsp_rdata);
		tally_and_finish();
	end
	initial begin
		#200000;
		err_count++;
		tally_and_finish();
	end
endmodule
bind host_bus_master bus_chk u_chk (.mclk, .arst_n, .clk_en, .rsp_valid, .irq_pending,
	.master_reset_n,
	.chip_select_n, .write_not_read, .addr, .data_oe_n, .interrupt_request_n, .int_ack_cycle_n);
`default_nettype wire
